//--- core/mod_ctl_pkg.sv
// constants and carrier types for the module control and status pin timing
// assumes a 40 MHz core clock; all times are converted to cycle counts here
package mod_ctl_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned INIT_TIME_MS = 300;
	localparam int unsigned INT_ASSERT_MS = 200;
	localparam int unsigned INT_NEGATE_US = 500;
	localparam int unsigned PDOWN_ENTER_US = 100;
	localparam int unsigned NOT_READY_ASSERT_DELAY_MS = 1;
	localparam int unsigned NOT_READY_NEGATE_DELAY_MS = 1;
	localparam int unsigned RESET_PULSE_MIN_US = 10;
	// longest times round down, least times round up
	localparam int unsigned INIT_CYC = INIT_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned INT_ASSERT_CYC = INT_ASSERT_MS * (CLK_HZ / 1000);
	localparam int unsigned INT_NEGATE_CYC = INT_NEGATE_US * (CLK_HZ / 1_000_000);
	localparam int unsigned PDOWN_ENTER_CYC = PDOWN_ENTER_US * (CLK_HZ / 1_000_000);
	localparam int unsigned NR_ON_CYC = NOT_READY_ASSERT_DELAY_MS * (CLK_HZ / 1000);
	localparam int unsigned NR_OFF_CYC = NOT_READY_NEGATE_DELAY_MS * (CLK_HZ / 1000);
	localparam int unsigned RESET_PULSE_CYC =
		(RESET_PULSE_MIN_US * CLK_HZ + 999_999) / 1_000_000;
	// delay the synchroniser adds before logic sees the power-down pin
	localparam int unsigned SYNC_CYC = 2;
	localparam int unsigned CNT_W = 24;

	typedef enum logic [1:0] {
		ST_INIT,
		ST_READY,
		ST_PDOWN
	} mod_state_t;

	typedef struct packed {
		logic out;
		logic oe;
	} od_pin_t;
endpackage

//--- core/sync2.sv
// two flip-flop synchroniser for a level from outside the clock domain
// assumes the level is held long enough to be seen at least once
`timescale 1ns/100ps
`default_nettype none
module sync2 (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic clk_en_i,
	// level in and out
	input wire logic async_i,
	output logic sync_o
);
	logic stage1;

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			stage1 <= 1'b0;
			sync_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule
`default_nettype wire

//--- core/mod_ctl_timing.sv
// module-side timing of the power-down/reset input and the interrupt and
// not-ready open-drain outputs; assumes host pull-ups on both outputs
//
// Behaviour
// - initialisation ends within 300 ms of power-on or power-down pin release
// - interrupt output asserts within 200 ms of a triggering condition
// - a clearing read of the flags negates interrupt within 500 us
// - power-down is entered within 100 us of the host asserting the pin
// - not-ready asserts within 1 ms of a fault occurring
// - not-ready negates within 1 ms of the fault clearing
// - a pin assertion held 10 us or longer starts a reset
`timescale 1ns/100ps
`default_nettype none
module mod_ctl_timing (
	// clock, reset, enable
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic clk_en_i,
	// host pin: power-down/reset, high means power-down asserted
	input wire logic pdown_rst_i,
	// module-internal events, same clock domain
	input wire logic int_event_i,
	input wire logic flags_read_i,
	input wire logic fault_i,
	input wire logic init_done_i,
	// open-drain pins, interrupt low active, not-ready high active
	output logic int_n_out_o,
	output logic int_n_oe_o,
	output logic module_not_ready_out_o,
	output logic module_not_ready_oe_o,
	// status toward the module core
	output logic pdown_o,
	output logic core_rst_o,
	output logic ready_o
);
	mod_ctl_pkg::mod_state_t state;
	mod_ctl_pkg::mod_state_t next_state;
	logic pin_sync;
	logic [mod_ctl_pkg::CNT_W-1:0] pulse_cnt;
	logic [mod_ctl_pkg::CNT_W-1:0] init_cnt;
	logic int_flag;
	logic nr_state;

	sync2 u_pin_sync (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.clk_en_i(clk_en_i),
		.async_i(pdown_rst_i),
		.sync_o(pin_sync)
	);

	// pulse width measurement; saturates at the minimum reset width
	wire pulse_long = (pulse_cnt >= mod_ctl_pkg::CNT_W'(mod_ctl_pkg::RESET_PULSE_CYC));
	wire init_timeout = (init_cnt >= mod_ctl_pkg::CNT_W'(mod_ctl_pkg::INIT_CYC - 4));
	wire init_finish = init_done_i || init_timeout;
	// not-ready while initialising, powered down or faulted
	wire nr_want = fault_i || (state != mod_ctl_pkg::ST_READY);
	// the set wins over a clearing read in the same cycle
	wire next_int_flag = int_event_i || (int_flag && !flags_read_i);

	always_comb
	begin
		next_state = state;
		unique case (state)
			mod_ctl_pkg::ST_INIT:
				if (pin_sync)
					next_state = mod_ctl_pkg::ST_PDOWN;
				else if (init_finish)
					next_state = mod_ctl_pkg::ST_READY;
			mod_ctl_pkg::ST_READY:
				if (pin_sync)
					next_state = mod_ctl_pkg::ST_PDOWN;
			mod_ctl_pkg::ST_PDOWN:
				if (!pin_sync)
					next_state = mod_ctl_pkg::ST_INIT;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state <= mod_ctl_pkg::ST_INIT;
			pulse_cnt <= '0;
			init_cnt <= '0;
			int_flag <= 1'b0;
			nr_state <= 1'b1;
		end
		else if (clk_en_i)
		begin
			state <= next_state;
			pulse_cnt <= !pin_sync ? '0 : (pulse_long ? pulse_cnt : pulse_cnt + 1'b1);
			init_cnt <= (state == mod_ctl_pkg::ST_INIT) ? init_cnt + 1'b1 : '0;
			int_flag <= next_int_flag;
			nr_state <= nr_want;
		end
	end

	// outputs all from flip-flops; open-drain only drives low
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			int_n_out_o <= 1'b0;
			int_n_oe_o <= 1'b0;
			module_not_ready_out_o <= 1'b0;
			module_not_ready_oe_o <= 1'b0;
			pdown_o <= 1'b0;
			core_rst_o <= 1'b1;
			ready_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			int_n_out_o <= 1'b0;
			int_n_oe_o <= int_flag;
			module_not_ready_out_o <= 1'b0;
			// pin high means not ready, so the pull is released while not ready
			module_not_ready_oe_o <= !nr_state;
			pdown_o <= (state == mod_ctl_pkg::ST_PDOWN);
			core_rst_o <= (state == mod_ctl_pkg::ST_PDOWN && pulse_long)
				|| (state == mod_ctl_pkg::ST_INIT);
			ready_o <= (state == mod_ctl_pkg::ST_READY);
		end
	end

	// helper: cycles since a clearing read with no new event
	logic [15:0] neg_cnt;
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			neg_cnt <= '0;
		else if (clk_en_i)
			neg_cnt <= (int_n_oe_o && !int_flag) ? neg_cnt + 1'b1 : '0;
	end

	property p_int_assert;
		@(posedge core_clk_i) disable iff (!arst_n_i || !clk_en_i)
		(clk_en_i && int_event_i) |-> ##2 int_n_oe_o;
	endproperty
	a_int_assert: assert property (p_int_assert) else $error("interrupt flag not set");

	property p_int_negate;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		neg_cnt < 16'(mod_ctl_pkg::INT_NEGATE_CYC);
	endproperty
	a_int_negate: assert property (p_int_negate) else $error("interrupt held after clear");

	property p_set_wins;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(clk_en_i && int_event_i && flags_read_i) |=> int_flag;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost on clearing read");

	property p_pdown_enter;
		@(posedge core_clk_i) disable iff (!arst_n_i || !clk_en_i)
		$rose(pin_sync) |-> ##[1:3] pdown_o;
	endproperty
	a_pdown_enter: assert property (p_pdown_enter) else $error("power-down entry late");

	property p_nr_assert;
		@(posedge core_clk_i) disable iff (!arst_n_i || !clk_en_i)
		fault_i |-> ##[1:2] !module_not_ready_oe_o;
	endproperty
	a_nr_assert: assert property (p_nr_assert) else $error("not-ready late on fault");

	property p_nr_negate;
		@(posedge core_clk_i) disable iff (!arst_n_i || !clk_en_i)
		(!fault_i && state == mod_ctl_pkg::ST_READY) [*2] |=> module_not_ready_oe_o;
	endproperty
	a_nr_negate: assert property (p_nr_negate) else $error("not-ready stuck");

	property p_init_bound;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		init_cnt < mod_ctl_pkg::CNT_W'(mod_ctl_pkg::INIT_CYC);
	endproperty
	a_init_bound: assert property (p_init_bound) else $error("initialisation overran");

	property p_short_pulse;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(core_rst_o && pdown_o) |-> $past(pulse_long);
	endproperty
	a_short_pulse: assert property (p_short_pulse) else $error("reset from short pulse");

	property p_od_low;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		!int_n_out_o && !module_not_ready_out_o;
	endproperty
	a_od_low: assert property (p_od_low) else $error("open-drain drives high");

	// output and flag checks of the remaining timing paths
	property p_int_clear;
		@(posedge core_clk_i) disable iff (!arst_n_i || !clk_en_i)
		(flags_read_i && !int_event_i) |-> ##2 !int_n_oe_o;
	endproperty
	a_int_clear: assert property (p_int_clear) else $error("interrupt held after read");

	property p_flag_hold;
		@(posedge core_clk_i) disable iff (!arst_n_i || !clk_en_i)
		(int_flag && !flags_read_i) |=> int_flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag lost without read");

	property p_rst_long;
		@(posedge core_clk_i) disable iff (!arst_n_i || !clk_en_i)
		(state == mod_ctl_pkg::ST_PDOWN && pulse_long) |=> core_rst_o;
	endproperty
	a_rst_long: assert property (p_rst_long) else $error("long pulse gave no reset");

	property p_pdown_exit;
		@(posedge core_clk_i) disable iff (!arst_n_i || !clk_en_i)
		$fell(pin_sync) |-> ##[1:3] !pdown_o;
	endproperty
	a_pdown_exit: assert property (p_pdown_exit) else $error("power-down not left");

	property p_init_rst;
		@(posedge core_clk_i) disable iff (!arst_n_i || !clk_en_i)
		(state == mod_ctl_pkg::ST_INIT) |=> core_rst_o;
	endproperty
	a_init_rst: assert property (p_init_rst) else $error("core not reset in init");

	property p_pdown_nr;
		@(posedge core_clk_i) disable iff (!arst_n_i || !clk_en_i)
		pdown_o |=> !module_not_ready_oe_o;
	endproperty
	a_pdown_nr: assert property (p_pdown_nr) else $error("ready shown in power-down");
endmodule
`default_nettype wire

//--- verif/host_model.sv
// host board side: pull-ups on the status pins, driver of the power-down pin
// assumes the bench sets the pin request at clock edges
`timescale 1ns/100ps
`default_nettype none
module host_model (
	// clock
	input wire logic core_clk_i,
	// bench request and the pin it drives
	input wire logic pd_req_i,
	output logic pdown_rst_o,
	// open-drain pins from the module and their resolved levels
	input wire logic int_n_out_i,
	input wire logic int_n_oe_i,
	input wire logic nr_out_i,
	input wire logic nr_oe_i,
	output logic int_n_pin_o,
	output logic nr_pin_o
);
	// pin held for as long as the bench holds the request
	always @(posedge core_clk_i)
		pdown_rst_o <= pd_req_i;
	assign int_n_pin_o = int_n_oe_i ? int_n_out_i : 1'b1;
	assign nr_pin_o = nr_oe_i ? nr_out_i : 1'b1;
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// bench for the control and status pin timing block
// assumes mod_ctl_pkg, sync2 and mod_ctl_timing are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic core_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic pd_req = 1'b0;
	logic int_event_i = 1'b0;
	logic flags_read_i = 1'b0;
	logic fault_i = 1'b0;
	logic init_done_i = 1'b0;
	wire logic pdown_rst, int_n_out, int_n_oe, nr_out, nr_oe;
	wire logic pdown, core_rst, ready, int_pin, nr_pin;
	int mismatches = 0;
	int num_checks = 0;
	initial forever #12.5 core_clk_i = ~core_clk_i;
	host_model i_host_model (.core_clk_i(core_clk_i), .pd_req_i(pd_req),
		.pdown_rst_o(pdown_rst), .int_n_out_i(int_n_out), .int_n_oe_i(int_n_oe),
		.nr_out_i(nr_out), .nr_oe_i(nr_oe), .int_n_pin_o(int_pin), .nr_pin_o(nr_pin));
	mod_ctl_timing i_mod_ctl_timing (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
		.clk_en_i(1'b1), .pdown_rst_i(pdown_rst), .int_event_i(int_event_i),
		.flags_read_i(flags_read_i), .fault_i(fault_i), .init_done_i(init_done_i),
		.int_n_out_o(int_n_out), .int_n_oe_o(int_n_oe), .module_not_ready_out_o(nr_out),
		.module_not_ready_oe_o(nr_oe), .pdown_o(pdown), .core_rst_o(core_rst),
		.ready_o(ready));
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic seen, input logic exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %b seen %b", what, exp, seen);
		end
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return int_pin;
			1: return nr_pin;
			2: return pdown;
			default: return ready;
		endcase
	endfunction
	task automatic edges(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic wait_for(input int s, input logic v, input int n);
		for (int i = 0; i < n && pick(s) !== v; i++)
			edges(1);
		if (pick(s) !== v)
		begin
			mismatches++;
			$display("ERROR wait on %0d expected %b seen %b", s, v, pick(s));
			conclude();
		end
	endtask
	task automatic pulse_done;
		@(posedge core_clk_i);
		init_done_i <= 1'b1;
		@(posedge core_clk_i);
		init_done_i <= 1'b0;
		wait_for(3, 1'b1, 1000);
	endtask
	task automatic t_boot;
		chk("core reset", core_rst, 1'b1);
		chk("not ready pin", nr_pin, 1'b1);
		pulse_done();
		// the not-ready pull follows ready by one cycle
		wait_for(1, 1'b0, 4);
		chk("core reset", core_rst, 1'b0);
		chk("not ready pin", nr_pin, 1'b0);
		chk("interrupt pin", int_pin, 1'b1);
		$display("test boot done");
	endtask
	task automatic t_int;
		@(posedge core_clk_i);
		int_event_i <= 1'b1;
		@(posedge core_clk_i);
		int_event_i <= 1'b0;
		#1 chk("interrupt pin", int_pin, 1'b1);
		edges(1);
		chk("interrupt pin", int_pin, 1'b0);
		@(posedge core_clk_i);
		int_event_i <= 1'b1;
		flags_read_i <= 1'b1;
		@(posedge core_clk_i);
		int_event_i <= 1'b0;
		flags_read_i <= 1'b0;
		edges(2);
		chk("interrupt pin", int_pin, 1'b0);
		@(posedge core_clk_i);
		flags_read_i <= 1'b1;
		@(posedge core_clk_i);
		flags_read_i <= 1'b0;
		edges(1);
		chk("interrupt pin", int_pin, 1'b1);
		$display("test interrupt done");
	endtask
	task automatic t_fault;
		@(posedge core_clk_i);
		fault_i <= 1'b1;
		wait_for(1, 1'b1, 40000);
		chk("not ready pin", nr_pin, 1'b1);
		@(posedge core_clk_i);
		fault_i <= 1'b0;
		wait_for(1, 1'b0, 40000);
		chk("not ready pin", nr_pin, 1'b0);
		$display("test fault done");
	endtask
	task automatic t_pdown(input int len, input logic rst_exp);
		@(posedge core_clk_i);
		pd_req <= 1'b1;
		wait_for(2, 1'b1, 4000);
		chk("power down", pdown, 1'b1);
		edges(len);
		chk("core reset", core_rst, rst_exp);
		chk("not ready pin", nr_pin, 1'b1);
		@(posedge core_clk_i);
		pd_req <= 1'b0;
		// init done is only taken once the block is back in initialisation
		wait_for(2, 1'b0, 8);
		pulse_done();
		chk("power down", pdown, 1'b0);
		$display("test power down %0d done", len);
	endtask
	task automatic t_reset;
		@(posedge core_clk_i);
		int_event_i <= 1'b1;
		@(posedge core_clk_i);
		int_event_i <= 1'b0;
		wait_for(0, 1'b0, 4);
		@(posedge core_clk_i);
		arst_n_i <= 1'b0;
		edges(2);
		chk("core reset", core_rst, 1'b1);
		chk("interrupt pin", int_pin, 1'b1);
		chk("not ready pin", nr_pin, 1'b1);
		chk("power down", pdown, 1'b0);
		@(posedge core_clk_i);
		arst_n_i <= 1'b1;
		edges(2);
		chk("core reset", core_rst, 1'b1);
		chk("ready", ready, 1'b0);
		pulse_done();
		wait_for(1, 1'b0, 4);
		chk("interrupt pin", int_pin, 1'b1);
		$display("test reset done");
	endtask
	initial
	begin
		repeat (16) @(posedge core_clk_i);
		arst_n_i <= 1'b1;
		edges(1);
		t_boot();
		t_int();
		t_fault();
		t_pdown(100, 1'b0);
		t_pdown(500, 1'b1);
		t_reset();
		conclude();
	end
endmodule
`default_nettype wire
